// ===== hdl/wr_burst_pkg.sv
// Shared constants for the burst write port and its controller
package wr_burst_pkg;
  // Burst type codes
  localparam logic [1:0] BURST_FIXED = 2'h0;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] BURST_WRAP = 2'h2;
  // Completion codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Variant select
  localparam bit VARIANT_AXI3 = 1'b0;
  localparam bit VARIANT_AXI4 = 1'b1;
  localparam int LEN_W_AXI3 = 4;
  // Controller register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_XFER = 8'h08;
  localparam logic [7:0] OFS_ATTR = 8'h0C;
  localparam logic [7:0] OFS_SEED = 8'h10;
  localparam logic [7:0] OFS_STRB = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // Field positions
  localparam int CTRL_START = 0;
  localparam int XFER_LEN = 0;
  localparam int XFER_SIZE = 8;
  localparam int XFER_BURST = 12;
  localparam int XFER_ID = 16;
  localparam int ATTR_LOCK = 0;
  localparam int ATTR_CACHE = 4;
  localparam int ATTR_PROT = 8;
  localparam int ATTR_QOS = 12;
  localparam int ATTR_REGION = 16;
  localparam int ATTR_USER = 20;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_RESP = 2;
  localparam int STAT_ID = 8;
  // Reset values
  localparam logic [31:0] XFER_RST = 32'h0000_1200;
  localparam logic [31:0] STRB_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage

// ===== hdl/wr_burst_if.sv
// Write-side channel bundle joining the controller and the port
`timescale 1ns/1ps
`default_nettype none
interface wr_burst_if #(
  parameter int ID_W = 4,
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32,
  parameter int USER_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn
);
  logic [ID_W-1:0] awid;
  logic [ADDR_W-1:0] awaddr;
  logic [7:0] awlen;
  logic [2:0] awsize;
  logic [1:0] awburst;
  logic [1:0] awlock;
  logic [3:0] awcache;
  logic [2:0] awprot;
  logic [3:0] awqos;
  logic [3:0] awregion;
  logic [USER_W-1:0] awuser;
  logic awvalid;
  logic awready;
  logic [ID_W-1:0] wid;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W/8-1:0] wstrb;
  logic wlast;
  logic [USER_W-1:0] wuser;
  logic wvalid;
  logic wready;
  logic [ID_W-1:0] bid;
  logic [1:0] bresp;
  logic [USER_W-1:0] buser;
  logic bvalid;
  logic bready;
  modport master (
    input aclk, aresetn, awready, wready, bid, bresp, buser, bvalid,
    output awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot,
    output awqos, awregion, awuser, awvalid, wid, wdata, wstrb, wlast,
    output wuser, wvalid, bready
  );
  modport slave (
    input aclk, aresetn, awid, awaddr, awlen, awsize, awburst, awlock,
    input awcache, awprot, awqos, awregion, awuser, awvalid, wid, wdata,
    input wstrb, wlast, wuser, wvalid, bready,
    output awready, wready, bid, bresp, buser, bvalid
  );
endinterface
`default_nettype wire

// ===== hdl/wr_burst_port.sv
// Device end: burst write slave into a byte-laned word memory
`timescale 1ns/1ps
`default_nettype none
module wr_burst_port #(
  parameter int ID_W = 4,
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32,
  parameter int USER_W = 8,
  parameter int DEPTH = 256,
  parameter bit VARIANT = wr_burst_pkg::VARIANT_AXI4
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  wr_burst_if.slave bus,
  input wire logic [$clog2(DEPTH)-1:0] I_PEEK_IDX,
  output logic [DATA_W-1:0] O_PEEK_DATA,
  output logic O_BURST_DONE
);
  localparam int LANES = DATA_W / 8;
  localparam int LSB = $clog2(LANES);
  localparam int IDX_W = $clog2(DEPTH);

  if (DATA_W < 8 || DATA_W > 1024 || (DATA_W & (DATA_W - 1)) != 0 || ADDR_W < LSB + IDX_W)
  begin : g_bad_cfg
    $error("wr_burst_port: unsupported DATA_W, ADDR_W or DEPTH");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_RESP = 2'b11
  } state_t;

  state_t state_ff;
  logic rst;
  logic awready_ff, wready_ff, bvalid_ff, done_ff;
  logic [ID_W-1:0] id_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0] len_ff, beat_ff;
  logic [2:0] size_ff;
  logic [1:0] burst_ff, resp_ff;
  logic aw_hs, w_hs, last_beat, in_range, beat_err;
  logic [ADDR_W-1:0] nxt_addr, step, wrap_mask, incr_addr;
  logic [IDX_W-1:0] word_idx;

  // Reset from either the system or the channel reset, the latter low-active
  assign rst = I_SYS_RST | ~bus.aresetn;
  assign aw_hs = bus.awvalid & awready_ff;
  assign w_hs = bus.wvalid & wready_ff;
  assign last_beat = (beat_ff == len_ff);
  assign word_idx = addr_ff[LSB +: IDX_W];
  assign in_range = (addr_ff >> LSB) < ADDR_W'(DEPTH);
  // Trailing flag must agree with the beat count; AXI3 also checks the tag
  assign beat_err = (bus.wlast != last_beat) | ~in_range
                  | ((VARIANT == wr_burst_pkg::VARIANT_AXI3) && (bus.wid != id_ff));

  // Beat address stepping by burst type
  assign step = ADDR_W'(1) << size_ff;
  assign incr_addr = addr_ff + step;
  assign wrap_mask = (ADDR_W'({24'h00_0000, len_ff}) + ADDR_W'(1)) * step - ADDR_W'(1);
  always_comb
  begin
    unique case (burst_ff)
      wr_burst_pkg::BURST_FIXED: nxt_addr = addr_ff;
      wr_burst_pkg::BURST_WRAP: nxt_addr = (addr_ff & ~wrap_mask) | (incr_addr & wrap_mask);
      default: nxt_addr = incr_addr;
    endcase
  end

  always_ff @(posedge I_CLK or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE:
        begin
          awready_ff <= ~aw_hs;
          if (aw_hs)
          begin
            state_ff <= ST_DATA;
            wready_ff <= 1'b1;
          end
        end
        ST_DATA:
          // Exactly the announced beat count closes the data phase
          if (w_hs && last_beat)
          begin
            state_ff <= ST_RESP;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b1;
          end
        ST_RESP:
          if (bus.bready)
          begin
            state_ff <= ST_IDLE;
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            done_ff <= 1'b1;
          end
      endcase
    end
  end

  // Transaction context, captured with the address
  always_ff @(posedge I_CLK or posedge rst)
  begin
    if (rst)
    begin
      id_ff <= '0;
      addr_ff <= '0;
      len_ff <= 8'h00;
      size_ff <= 3'h0;
      burst_ff <= wr_burst_pkg::BURST_INCR;
      beat_ff <= 8'h00;
      resp_ff <= wr_burst_pkg::RESP_OKAY;
    end
    else if (aw_hs)
    begin
      id_ff <= bus.awid;
      addr_ff <= bus.awaddr;
      // AXI3 length field is four bits wide
      len_ff <= (VARIANT == wr_burst_pkg::VARIANT_AXI3) ? {4'h0, bus.awlen[3:0]} : bus.awlen;
      size_ff <= bus.awsize;
      burst_ff <= bus.awburst;
      beat_ff <= 8'h00;
      // Beats wider than the bus cannot be served
      resp_ff <= (bus.awsize > 3'(LSB)) ? wr_burst_pkg::RESP_SLVERR : wr_burst_pkg::RESP_OKAY;
    end
    else if (w_hs)
    begin
      addr_ff <= nxt_addr;
      beat_ff <= beat_ff + 8'h01;
      if (beat_err)
        resp_ff <= wr_burst_pkg::RESP_SLVERR;
    end
  end

  // Byte-laned word memory, written only where the strobe is set
  logic [LANES-1:0][7:0] mem [DEPTH];
  always_ff @(posedge I_CLK)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (w_hs && in_range && bus.wstrb[i])
        mem[word_idx][i] <= bus.wdata[8*i +: 8];
    end
  end

  // One process owns the whole peek word
  always_ff @(posedge I_CLK or posedge rst)
  begin
    if (rst)
      O_PEEK_DATA <= '0;
    else
      O_PEEK_DATA <= mem[I_PEEK_IDX];
  end

  assign O_BURST_DONE = done_ff;
  // All channel outputs straight from flops or tied to zero
  assign bus.awready = awready_ff;
  assign bus.wready = wready_ff;
  assign bus.bvalid = bvalid_ff;
  assign bus.bresp = resp_ff;
  assign bus.bid = id_ff;
  assign bus.buser = '0;
endmodule
`default_nettype wire

// ===== hdl/wr_burst_ctrl.sv
// Far end: APB-programmed controller that issues one write burst per start
`timescale 1ns/1ps
`default_nettype none
// Function
// - Sample every channel signal on rising edge
// - Channel reset is active low
// - Address gives the first beat byte address
// - Length gives exact beat count
// - Size gives bytes per beat
// - Burst type selects beat address stepping
// - Lock attribute travels with the address
// - Cache attribute states handling needs
// - Protection gives privilege, security, access type
// - QoS, region, user only in AXI4
// - Address valid from master, ready from slave
// - Data tag only in AXI3
// - Strobes mark meaningful bytes; slave honours them
// - Last flag only on final beat
// - Data valid from master, ready from slave
// - Slave returns status of whole write
// - Slave tags every response
// - Response valid from slave, ready from master
// - Data and response user fields AXI4 only
// - Valids held low during reset
// - No combinational input-to-output path
// - One strobe per data byte
// - One response per burst
module wr_burst_ctrl #(
  parameter int ID_W = 4,
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32,
  parameter int USER_W = 8,
  parameter bit VARIANT = wr_burst_pkg::VARIANT_AXI4
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  wr_burst_if.master bus
);
  localparam int LANES = DATA_W / 8;

  if (DATA_W < 8 || DATA_W > 256 || (DATA_W & (DATA_W - 1)) != 0 || ADDR_W > 32
      || ID_W > 8 || USER_W > 8)
  begin : g_bad_cfg
    $error("wr_burst_ctrl: unsupported width parameter");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b11,
    ST_RESP = 2'b10
  } state_t;

  state_t state_ff;
  logic rst;
  logic setup, wr_acc, start;
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff, nxt_prdata;
  logic map_hit;
  logic [31:0] addr_ff, xfer_ff, attr_ff, seed_ff, strb_ff;
  logic done_ff;
  logic [1:0] stat_resp_ff;
  logic [7:0] stat_id_ff;
  logic awvalid_ff, wvalid_ff, wlast_ff, bready_ff;
  logic [7:0] len_ff, beat_ff;
  logic [ID_W-1:0] id_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic aw_hs, w_hs, b_hs;
  logic [7:0] req_len;

  // Channel reset is low-active; either reset idles the controller
  assign rst = I_SYS_RST | ~bus.aresetn;

  // APB slave: answer comes in the first access cycle
  assign setup = I_PSEL & ~I_PENABLE;
  assign wr_acc = I_PSEL & I_PENABLE & pready_ff & I_PWRITE;
  // A start while a burst is in flight is dropped
  assign start = wr_acc && (I_PADDR == wr_burst_pkg::OFS_CTRL)
               && I_PWDATA[wr_burst_pkg::CTRL_START] && (state_ff == ST_IDLE);

  always_comb
  begin
    map_hit = 1'b1;
    nxt_prdata = 32'h0000_0000;
    unique case (I_PADDR)
      wr_burst_pkg::OFS_CTRL: nxt_prdata = 32'h0000_0000;
      wr_burst_pkg::OFS_ADDR: nxt_prdata = addr_ff;
      wr_burst_pkg::OFS_XFER: nxt_prdata = xfer_ff;
      wr_burst_pkg::OFS_ATTR: nxt_prdata = attr_ff;
      wr_burst_pkg::OFS_SEED: nxt_prdata = seed_ff;
      wr_burst_pkg::OFS_STRB: nxt_prdata = strb_ff;
      wr_burst_pkg::OFS_STAT:
      begin
        nxt_prdata[wr_burst_pkg::STAT_BUSY] = (state_ff != ST_IDLE);
        nxt_prdata[wr_burst_pkg::STAT_DONE] = done_ff;
        nxt_prdata[wr_burst_pkg::STAT_RESP +: 2] = stat_resp_ff;
        nxt_prdata[wr_burst_pkg::STAT_ID +: 8] = stat_id_ff;
      end
      default: map_hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK or posedge rst)
  begin
    if (rst)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= wr_burst_pkg::WORD_RST;
    end
    else
    begin
      pready_ff <= setup;
      if (setup)
      begin
        pslverr_ff <= ~map_hit;
        prdata_ff <= I_PWRITE ? wr_burst_pkg::WORD_RST : nxt_prdata;
      end
    end
  end

  // Software-written setup registers
  always_ff @(posedge I_CLK or posedge rst)
  begin
    if (rst)
    begin
      addr_ff <= wr_burst_pkg::WORD_RST;
      xfer_ff <= wr_burst_pkg::XFER_RST;
      attr_ff <= wr_burst_pkg::WORD_RST;
      seed_ff <= wr_burst_pkg::WORD_RST;
      strb_ff <= wr_burst_pkg::STRB_RST;
    end
    else if (wr_acc)
    begin
      unique case (I_PADDR)
        wr_burst_pkg::OFS_ADDR: addr_ff <= I_PWDATA;
        wr_burst_pkg::OFS_XFER: xfer_ff <= I_PWDATA;
        wr_burst_pkg::OFS_ATTR: attr_ff <= I_PWDATA;
        wr_burst_pkg::OFS_SEED: seed_ff <= I_PWDATA;
        wr_burst_pkg::OFS_STRB: strb_ff <= I_PWDATA;
        default: ;
      endcase
    end
  end

  assign aw_hs = awvalid_ff & bus.awready;
  assign w_hs = wvalid_ff & bus.wready;
  assign b_hs = bready_ff & bus.bvalid;
  // AXI3 carries only four length bits
  assign req_len = (VARIANT == wr_burst_pkg::VARIANT_AXI3)
                 ? {4'h0, xfer_ff[wr_burst_pkg::XFER_LEN +: wr_burst_pkg::LEN_W_AXI3]}
                 : xfer_ff[wr_burst_pkg::XFER_LEN +: 8];

  always_ff @(posedge I_CLK or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      awvalid_ff <= 1'b0;
      wvalid_ff <= 1'b0;
      wlast_ff <= 1'b0;
      bready_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
          if (start)
          begin
            state_ff <= ST_ADDR;
            awvalid_ff <= 1'b1;
          end
        ST_ADDR:
          // Data follows the accepted address; simpler than overlapping channels
          if (aw_hs)
          begin
            state_ff <= ST_DATA;
            awvalid_ff <= 1'b0;
            wvalid_ff <= 1'b1;
            wlast_ff <= (len_ff == 8'h00);
          end
        ST_DATA:
          if (w_hs)
          begin
            wlast_ff <= (beat_ff + 8'h01 == len_ff);
            if (wlast_ff)
            begin
              state_ff <= ST_RESP;
              wvalid_ff <= 1'b0;
              wlast_ff <= 1'b0;
              bready_ff <= 1'b1;
            end
          end
        ST_RESP:
          if (b_hs)
          begin
            state_ff <= ST_IDLE;
            bready_ff <= 1'b0;
          end
      endcase
    end
  end

  // Beat count and pattern data: beat n carries seed plus n in each word
  always_ff @(posedge I_CLK or posedge rst)
  begin
    if (rst)
    begin
      len_ff <= 8'h00;
      id_ff <= '0;
      beat_ff <= 8'h00;
      wdata_ff <= '0;
    end
    else if (start)
    begin
      len_ff <= req_len;
      id_ff <= xfer_ff[wr_burst_pkg::XFER_ID +: ID_W];
      beat_ff <= 8'h00;
      wdata_ff <= DATA_W'({(DATA_W + 31) / 32 {seed_ff}});
    end
    else if (w_hs)
    begin
      beat_ff <= beat_ff + 8'h01;
      wdata_ff <= DATA_W'({(DATA_W + 31) / 32 {seed_ff + 32'({24'h00_0000, beat_ff})
                                              + 32'h0000_0001}});
    end
  end

  // Status: completion wins over the clear done by a new start
  always_ff @(posedge I_CLK or posedge rst)
  begin
    if (rst)
    begin
      done_ff <= 1'b0;
      stat_resp_ff <= wr_burst_pkg::RESP_OKAY;
      stat_id_ff <= 8'h00;
    end
    else if (b_hs)
    begin
      done_ff <= 1'b1;
      stat_resp_ff <= bus.bresp;
      stat_id_ff <= 8'(bus.bid);
    end
    else if (start)
      done_ff <= 1'b0;
  end

  assign O_PRDATA = prdata_ff;
  assign O_PREADY = pready_ff;
  assign O_PSLVERR = pslverr_ff;

  // Every channel output comes from a flop or is tied to zero
  assign bus.awvalid = awvalid_ff;
  assign bus.awid = id_ff;
  assign bus.awaddr = addr_ff[ADDR_W-1:0];
  assign bus.awlen = len_ff;
  assign bus.awsize = xfer_ff[wr_burst_pkg::XFER_SIZE +: 3];
  assign bus.awburst = xfer_ff[wr_burst_pkg::XFER_BURST +: 2];
  assign bus.awlock = attr_ff[wr_burst_pkg::ATTR_LOCK +: 2];
  assign bus.awcache = attr_ff[wr_burst_pkg::ATTR_CACHE +: 4];
  assign bus.awprot = attr_ff[wr_burst_pkg::ATTR_PROT +: 3];
  // Fields absent from the variant are held at zero
  assign bus.awqos = VARIANT ? attr_ff[wr_burst_pkg::ATTR_QOS +: 4] : 4'h0;
  assign bus.awregion = VARIANT ? attr_ff[wr_burst_pkg::ATTR_REGION +: 4] : 4'h0;
  assign bus.awuser = VARIANT ? attr_ff[wr_burst_pkg::ATTR_USER +: USER_W] : '0;
  assign bus.wid = VARIANT ? '0 : id_ff;
  assign bus.wuser = '0;
  assign bus.wvalid = wvalid_ff;
  assign bus.wdata = wdata_ff;
  assign bus.wstrb = strb_ff[LANES-1:0];
  assign bus.wlast = wlast_ff;
  assign bus.bready = bready_ff;
endmodule
`default_nettype wire

// ===== verif/wr_burst_chk.sv
// Protocol checker for the burst write link between controller and port
`timescale 1ns/1ps
`default_nettype none
module wr_burst_chk #(
  parameter int ID_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ID_W-1:0] awid,
  input wire logic [7:0] awlen,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [ID_W-1:0] wid,
  input wire logic wlast,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [ID_W-1:0] bid,
  input wire logic bvalid,
  input wire logic bready
);
  logic [7:0] len_ff;
  logic [7:0] beat_ff;
  logic [ID_W-1:0] id_ff;
  logic open_ff;
  logic pend_ff;
  wire logic aw_hs = awvalid && awready;
  wire logic w_hs = wvalid && wready;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Beat bookkeeping of the accepted burst
  always_ff @(posedge aclk or negedge aresetn)
  begin
    if (!aresetn)
    begin
      len_ff <= 8'h00;
      beat_ff <= 8'h00;
      id_ff <= '0;
      open_ff <= 1'b0;
    end
    else if (aw_hs)
    begin
      len_ff <= awlen;
      beat_ff <= 8'h00;
      id_ff <= awid;
      open_ff <= 1'b1;
    end
    else if (w_hs)
    begin
      beat_ff <= beat_ff + 8'h01;
      open_ff <= !wlast;
    end
  end
  // Response owed once the final beat is in
  always_ff @(posedge aclk or negedge aresetn)
  begin
    if (!aresetn)
      pend_ff <= 1'b0;
    else if (w_hs && wlast)
      pend_ff <= 1'b1;
    else if (bvalid && bready)
      pend_ff <= 1'b0;
  end
  // Reset checks must stay live while reset is held
  chk_aw_w_reset: assert property (disable iff (1'b0) !aresetn |-> !awvalid && !wvalid)
    else $error("address or data valid high in reset");
  chk_b_reset: assert property (disable iff (1'b0) !aresetn |-> !bvalid)
    else $error("response valid high in reset");
  chk_aw_then_w: assert property (aw_hs |=> wready && !awready)
    else $error("address handshake not followed by data ready");
  chk_w_in_burst: assert property (wvalid |-> open_ff)
    else $error("data beat outside an accepted burst");
  chk_beat_count: assert property (w_hs && wlast |-> beat_ff == len_ff)
    else $error("last flag on wrong beat count");
  chk_last_only: assert property (w_hs && beat_ff != len_ff |-> !wlast)
    else $error("last flag before final beat");
  chk_resp_after: assert property (w_hs && wlast |=> bvalid)
    else $error("no response one cycle after final beat");
  chk_one_resp: assert property (bvalid |-> pend_ff)
    else $error("response without a completed burst");
  chk_bid_match: assert property (bvalid |-> bid == id_ff)
    else $error("response tag differs from address tag");
  chk_b_bounded: assert property ($rose(bvalid) |-> ##[0:4] (bvalid && bready))
    else $error("response handshake not completed");
  chk_wid_zero: assert property (wvalid |-> wid == '0)
    else $error("data tag driven in the newer variant");
  cov_aw: cover property (aw_hs);
  cov_multi: cover property (w_hs && wlast && beat_ff != 8'h00);
  cov_b: cover property (bvalid && bready);
endmodule
`default_nettype wire

// ===== verif/tb_burst_write_port_signals.sv
// Testbench: controller and port joined, bursts driven over the register bus
`timescale 1ns/1ps
`default_nettype none
module tb_burst_write_port_signals;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] peek_idx = 8'h00;
  logic [31:0] peek_data;
  logic [31:0] prdata3;
  logic [31:0] peek_data3;
  logic burst_done;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int pulses = 0;
  always #12.5 clk = ~clk;
  wr_burst_if u_wr_burst_if (.aclk(clk), .aresetn(~rst));
  wr_burst_ctrl u_wr_burst_ctrl (.I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .bus(u_wr_burst_if));
  wr_burst_port u_wr_burst_port (.I_CLK(clk), .I_SYS_RST(rst), .bus(u_wr_burst_if),
    .I_PEEK_IDX(peek_idx), .O_PEEK_DATA(peek_data), .O_BURST_DONE(burst_done));
  // Older variant pair shares the register bus and runs every burst in parallel
  wr_burst_if u_wr_burst_if_axi3 (.aclk(clk), .aresetn(~rst));
  wr_burst_ctrl #(.VARIANT(wr_burst_pkg::VARIANT_AXI3)) u_wr_burst_ctrl_axi3 (.I_CLK(clk),
    .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata3), .O_PREADY(), .O_PSLVERR(),
    .bus(u_wr_burst_if_axi3));
  wr_burst_port #(.VARIANT(wr_burst_pkg::VARIANT_AXI3)) u_wr_burst_port_axi3 (.I_CLK(clk),
    .I_SYS_RST(rst), .bus(u_wr_burst_if_axi3), .I_PEEK_IDX(peek_idx),
    .O_PEEK_DATA(peek_data3), .O_BURST_DONE());
  wr_burst_chk u_wr_burst_chk (.aclk(clk), .aresetn(~rst), .awid(u_wr_burst_if.awid),
    .awlen(u_wr_burst_if.awlen), .awvalid(u_wr_burst_if.awvalid),
    .awready(u_wr_burst_if.awready), .wid(u_wr_burst_if.wid), .wlast(u_wr_burst_if.wlast),
    .wvalid(u_wr_burst_if.wvalid), .wready(u_wr_burst_if.wready), .bid(u_wr_burst_if.bid),
    .bvalid(u_wr_burst_if.bvalid), .bready(u_wr_burst_if.bready));
  task automatic stop_test();
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Generous ceiling: whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (burst_done === 1'b1)
      pulses++;
    if (cycles == 20000)
    begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  function automatic logic [31:0] xf(input int len, input int sz, input logic [1:0] bt,
      input int id);
    return 32'(id << 16) | {18'h0, bt, 12'h0} | 32'(sz << 8) | 32'(len);
  endfunction
  task automatic peek(input logic [7:0] idx, input logic [31:0] exp);
    peek_idx <= idx;
    @(posedge clk);
    @(posedge clk);
    chk(peek_data, exp);
    chk(peek_data3, exp);
  endtask
  // One burst through the controller, then judge status and pulse count
  task automatic run(input logic [31:0] addr, input logic [31:0] x, input logic [31:0] seed,
      input logic [31:0] strb, input logic [1:0] resp);
    logic [31:0] q;
    logic e;
    int p0;
    p0 = pulses;
    wreg(wr_burst_pkg::OFS_ADDR, addr);
    wreg(wr_burst_pkg::OFS_XFER, x);
    wreg(wr_burst_pkg::OFS_SEED, seed);
    wreg(wr_burst_pkg::OFS_STRB, strb);
    wreg(wr_burst_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (40)
    begin
      apb(1'b0, wr_burst_pkg::OFS_STAT, 32'h0000_0000, q, e);
      if (q[wr_burst_pkg::STAT_DONE] === 1'b1)
        break;
    end
    chk({31'h0, q[1]}, 32'h0000_0001);
    chk({30'h0, q[3:2]}, {30'h0, resp});
    chk({24'h0, q[15:8]}, {24'h0, x[23:16]});
    chk(32'(pulses - p0), 32'h0000_0001);
    chk({30'h0, prdata3[3:2]}, {30'h0, resp});
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    apb(1'b0, wr_burst_pkg::OFS_XFER, 32'h0000_0000, q, e);
    chk(q, wr_burst_pkg::XFER_RST);
    apb(1'b0, wr_burst_pkg::OFS_STRB, 32'h0000_0000, q, e);
    chk(q, wr_burst_pkg::STRB_RST);
    apb(1'b0, 8'h1C, 32'h0000_0000, q, e);
    chk({q[31:1], e}, 32'h0000_0001);
    wreg(wr_burst_pkg::OFS_ATTR, 32'h0A5F_3A52);
    q = {4'h0, u_wr_burst_if.awuser, u_wr_burst_if.awregion, u_wr_burst_if.awqos, 1'b0,
      u_wr_burst_if.awprot, u_wr_burst_if.awcache, 2'h0, u_wr_burst_if.awlock};
    chk(q, 32'h0A5F_3252);
    q = {16'h0, u_wr_burst_if_axi3.awregion, u_wr_burst_if_axi3.awqos,
      u_wr_burst_if_axi3.awuser};
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_incr();
    run(32'h0000_0100, xf(3, 2, wr_burst_pkg::BURST_INCR, 5), 32'h1111_0000, 32'h0000_000F,
      wr_burst_pkg::RESP_OKAY);
    for (int n = 0; n < 4; n++)
      peek(8'(64 + n), 32'h1111_0000 + 32'(n));
  endtask
  task automatic t_strb();
    run(32'h0000_0100, xf(0, 2, wr_burst_pkg::BURST_INCR, 9), 32'hAAAA_AAAA, 32'h0000_0005,
      wr_burst_pkg::RESP_OKAY);
    peek(8'h40, 32'h11AA_00AA);
  endtask
  task automatic t_fixed();
    run(32'h0000_0104, xf(2, 2, wr_burst_pkg::BURST_FIXED, 3), 32'h2000_0000, 32'h0000_000F,
      wr_burst_pkg::RESP_OKAY);
    peek(8'h41, 32'h2000_0002);
    peek(8'h42, 32'h1111_0002);
  endtask
  task automatic t_wrap();
    run(32'h0000_0048, xf(3, 2, wr_burst_pkg::BURST_WRAP, 12), 32'h3000_0000, 32'h0000_000F,
      wr_burst_pkg::RESP_OKAY);
    peek(8'h12, 32'h3000_0000);
    peek(8'h13, 32'h3000_0001);
    peek(8'h10, 32'h3000_0002);
    peek(8'h11, 32'h3000_0003);
  endtask
  // Oversized beat and out-of-range start must both fail the whole write
  task automatic t_err();
    run(32'h0000_0200, xf(0, 3, wr_burst_pkg::BURST_INCR, 7), 32'h4000_0000, 32'h0000_000F,
      wr_burst_pkg::RESP_SLVERR);
    run(32'h0000_0400, xf(1, 2, wr_burst_pkg::BURST_INCR, 15), 32'h5000_0000, 32'h0000_000F,
      wr_burst_pkg::RESP_SLVERR);
  endtask
  initial
  begin
    // Raised in the NBA region so every async reset sees a real edge
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_incr();
    t_strb();
    t_fixed();
    t_wrap();
    t_err();
    stop_test();
  end
endmodule
`default_nettype wire
